// file: design/opc_ctrl.v
// apb control and status slice of the one-time-programmable controller
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`include "opc_regs.vh"

// three-stage synchroniser, output follows once stages two and three agree
module opc_sync3 (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // pin side and filtered level
  input wire din,
  output reg dout
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // shift chain and agreement filter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule // opc_sync3

module opc_ctrl (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // controller state from the same clock domain
  input wire [12:0] words_left,
  input wire [3:0] fifo_words,
  // macrocell side
  output reg [12:0] mc_addr,
  output reg [31:0] mc_mask,
  output reg [31:0] mc_data,
  output reg mc_prog_req,
  output reg mc_test_req,
  input wire mc_done,
  input wire mc_fail_upper,
  input wire mc_fail_lower,
  // interrupt
  output reg irq
);
  // one-hot sequencer states
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_PROG = 5'b00010;
  localparam [4:0] ST_TEST = 5'b00100;
  localparam [4:0] ST_DROP = 5'b01000;
  localparam [4:0] ST_QUIT = 5'b10000;

  reg [31:0] ctrl_q;
  reg [4:0] state_q;
  reg [4:0] state_d;
  reg perr_u_q;
  reg perr_l_q;
  reg perror_q;
  reg terr_u_q;
  reg terr_l_q;
  reg terror_q;
  reg [12:0] nwords_q;
  reg [3:0] fwords_q;
  reg [`OPC_IRQ_W-1:0] irqs_q;
  reg [`OPC_IRQ_W-1:0] irqm_q;
  reg [`OPC_IRQ_W-1:0] ev_d;
  reg [31:0] rdata_d;
  reg hit_d;
  reg [31:0] mask_d;
  reg [31:0] data_d;
  reg [4:0] upos;
  reg [4:0] lpos;
  wire done_f;
  wire fail_u_f;
  wire fail_l_f;
  wire acc;
  wire wr;
  wire start_prog;
  wire start_test;
  wire any_en;
  integer i;

  // pins from the macrocells cross in from outside the clock domain
  opc_sync3 u_sync_done (
    .pclk(pclk),
    .presetn(presetn),
    .din(mc_done),
    .dout(done_f)
  );
  opc_sync3 u_sync_fu (
    .pclk(pclk),
    .presetn(presetn),
    .din(mc_fail_upper),
    .dout(fail_u_f)
  );
  opc_sync3 u_sync_fl (
    .pclk(pclk),
    .presetn(presetn),
    .din(mc_fail_lower),
    .dout(fail_l_f)
  );

  // a transfer completes at the edge where pready is sampled high
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite & ~pslverr;
  assign start_prog = wr && (paddr == `OPC_CMD_ADDR) &&
    pwdata[`OPC_CMD_PROG] && (state_q == ST_IDLE);
  assign start_test = wr && (paddr == `OPC_CMD_ADDR) &&
    pwdata[`OPC_CMD_TEST] && !pwdata[`OPC_CMD_PROG] &&
    (state_q == ST_IDLE);
  assign any_en = ctrl_q[`OPC_ENU] | ctrl_q[`OPC_ENL];

  // bit positions inside the word, upper one down to lower zero
  always @* begin
    upos = (ctrl_q[`OPC_BSELU] ? `OPC_LANE_UP_ONE : `OPC_LANE_UP_ZERO) +
      {2'b00, ctrl_q[`OPC_BADRU]};
    lpos = (ctrl_q[`OPC_BSELL] ? `OPC_LANE_LO_ONE : `OPC_LANE_LO_ZERO) +
      {2'b00, ctrl_q[`OPC_BADRL]};
  end

  // program mask and value, one bit per enabled 16-bit bank
  always @* begin
    mask_d = `OPC_ZERO32;
    data_d = `OPC_ZERO32;
    for (i = 0; i < 32; i = i + 1) begin
      if (ctrl_q[`OPC_ENU] && (upos == i[4:0])) begin
        mask_d[i] = 1'b1;
        data_d[i] = ctrl_q[`OPC_BITU];
      end
      if (ctrl_q[`OPC_ENL] && (lpos == i[4:0])) begin
        mask_d[i] = 1'b1;
        data_d[i] = ctrl_q[`OPC_BITL];
      end
    end
  end

  // sequencer next state and events
  always @* begin
    state_d = state_q;
    ev_d = {`OPC_IRQ_W{1'b0}};
    case (state_q)
      ST_IDLE: begin
        if (start_prog && any_en) begin
          state_d = ST_PROG;
        end else if (start_prog) begin
          ev_d[`OPC_IRQ_PDONE] = 1'b1; // no bank enabled, nothing to do
        end else if (start_test) begin
          state_d = ST_TEST;
        end
      end
      ST_PROG: begin
        if (done_f) begin
          state_d = ST_DROP;
          ev_d[`OPC_IRQ_PDONE] = 1'b1;
          ev_d[`OPC_IRQ_PERR] = (ctrl_q[`OPC_ENU] & fail_u_f) |
            (ctrl_q[`OPC_ENL] & fail_l_f);
        end
      end
      ST_TEST: begin
        if (done_f) begin
          state_d = ST_DROP;
          ev_d[`OPC_IRQ_TDONE] = 1'b1;
          ev_d[`OPC_IRQ_TERR] = fail_u_f | fail_l_f;
        end
      end
      ST_DROP: begin
        state_d = ST_QUIT;
      end
      ST_QUIT: begin
        if (!done_f) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // sequencer, macrocell request and error capture
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      mc_addr <= `OPC_ZERO13;
      mc_mask <= `OPC_ZERO32;
      mc_data <= `OPC_ZERO32;
      mc_prog_req <= 1'b0;
      mc_test_req <= 1'b0;
      perr_u_q <= 1'b0;
      perr_l_q <= 1'b0;
      perror_q <= 1'b0;
      terr_u_q <= 1'b0;
      terr_l_q <= 1'b0;
      terror_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (start_prog && any_en) begin
        mc_addr <= ctrl_q[`OPC_WADDR];
        mc_mask <= mask_d;
        mc_data <= data_d;
        mc_prog_req <= 1'b1;
      end
      if (start_test) begin
        mc_test_req <= 1'b1;
      end
      if (state_q == ST_PROG && done_f) begin
        mc_prog_req <= 1'b0;
        perr_u_q <= ctrl_q[`OPC_ENU] & fail_u_f;
        perr_l_q <= ctrl_q[`OPC_ENL] & fail_l_f;
        perror_q <= ev_d[`OPC_IRQ_PERR];
      end
      if (state_q == ST_TEST && done_f) begin
        mc_test_req <= 1'b0;
        terr_u_q <= fail_u_f;
        terr_l_q <= fail_l_f;
        terror_q <= ev_d[`OPC_IRQ_TERR];
      end
    end
  end

  // register views of the controller counters
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nwords_q <= `OPC_ZERO13;
      fwords_q <= `OPC_ZERO4;
    end else begin
      nwords_q <= words_left;
      fwords_q <= fifo_words;
    end
  end

  // read mux and address decode
  always @* begin
    rdata_d = `OPC_ZERO32;
    hit_d = 1'b1;
    case (paddr)
      `OPC_CTRL_ADDR: begin
        rdata_d = ctrl_q;
      end
      `OPC_STAT_ADDR: begin
        rdata_d[`OPC_NWORDS] = nwords_q;
        rdata_d[`OPC_TERR_U] = terr_u_q;
        rdata_d[`OPC_TERR_L] = terr_l_q;
        rdata_d[`OPC_PERR_U] = perr_u_q;
        rdata_d[`OPC_PERR_L] = perr_l_q;
        rdata_d[`OPC_FWORDS] = fwords_q;
        rdata_d[`OPC_TERROR] = terror_q;
        rdata_d[`OPC_PERROR] = perror_q;
      end
      `OPC_CMD_ADDR: begin
        rdata_d[`OPC_CMD_PROG] = mc_prog_req;
        rdata_d[`OPC_CMD_TEST] = mc_test_req;
      end
      `OPC_IRQS_ADDR: begin
        rdata_d[`OPC_IRQ_W-1:0] = irqs_q;
      end
      `OPC_IRQM_ADDR: begin
        rdata_d[`OPC_IRQ_W-1:0] = irqm_q;
      end
      default: begin
        hit_d = 1'b0;
      end
    endcase
  end

  // apb answer: one wait state, data and error valid with pready
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `OPC_ZERO32;
    end else begin
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        pslverr <= ~hit_d;
        prdata <= pwrite ? `OPC_ZERO32 : rdata_d;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= `OPC_ZERO32;
      end
    end
  end

  // software registers; control is frozen while a sequence runs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `OPC_ZERO32;
      irqm_q <= {`OPC_IRQ_W{1'b0}};
    end else begin
      if (wr && paddr == `OPC_CTRL_ADDR && state_q == ST_IDLE) begin
        ctrl_q <= pwdata & `OPC_CTRL_WMASK;
      end
      if (wr && paddr == `OPC_IRQM_ADDR) begin
        irqm_q <= pwdata[`OPC_IRQ_W-1:0];
      end
    end
  end

  // sticky events, write one to clear, a new event beats the clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irqs_q <= {`OPC_IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      if (wr && paddr == `OPC_IRQS_ADDR) begin
        irqs_q <= (irqs_q & ~pwdata[`OPC_IRQ_W-1:0]) | ev_d;
      end else begin
        irqs_q <= irqs_q | ev_d;
      end
      irq <= |(irqs_q & irqm_q);
    end
  end
endmodule // opc_ctrl

// file: design/opc_regs.vh
// register map, field positions and reset values of the programming slice
`ifndef OPC_REGS_VH
`define OPC_REGS_VH
// byte addresses on the peripheral bus
`define OPC_CTRL_ADDR 32'h4000_8004
`define OPC_STAT_ADDR 32'h4000_8008
`define OPC_CMD_ADDR 32'h4000_8040
`define OPC_IRQS_ADDR 32'h4000_8044
`define OPC_IRQM_ADDR 32'h4000_8048
// reset and constant values
`define OPC_ZERO32 32'h0000_0000
`define OPC_ONE32 32'h0000_0001
`define OPC_ZERO4 4'h0
`define OPC_ZERO13 13'h0000
`define OPC_CTRL_WMASK 32'h0FFF_1FFF
// bit program control fields
`define OPC_ENU 27
`define OPC_BITU 26
`define OPC_ENL 25
`define OPC_BITL 24
`define OPC_BSELU 23
`define OPC_BADRU 22:20
`define OPC_BSELL 19
`define OPC_BADRL 18:16
`define OPC_WADDR 12:0
// controller status fields
`define OPC_NWORDS 28:16
`define OPC_TERR_U 15
`define OPC_TERR_L 14
`define OPC_PERR_U 13
`define OPC_PERR_L 12
`define OPC_FWORDS 11:8
`define OPC_TERROR 3
`define OPC_PERROR 1
// command bits
`define OPC_CMD_PROG 0
`define OPC_CMD_TEST 1
// interrupt bits
`define OPC_IRQ_W 4
`define OPC_IRQ_PDONE 0
`define OPC_IRQ_PERR 1
`define OPC_IRQ_TDONE 2
`define OPC_IRQ_TERR 3
// byte lane base positions, upper one at the top down to lower zero
`define OPC_LANE_UP_ONE 5'h18
`define OPC_LANE_LO_ONE 5'h10
`define OPC_LANE_UP_ZERO 5'h08
`define OPC_LANE_LO_ZERO 5'h00
`endif

// file: tb/opc_ctrl_checker.sv
// assertion checker for the programming slice
`timescale 1ns/10ps
`include "opc_regs.vh"
module opc_ctrl_checker (
  // clock, reset and apb
  input wire pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire [31:0] paddr, pwdata, prdata,
  // controller state and macrocell side
  input wire [12:0] words_left, mc_addr,
  input wire [3:0] fifo_words,
  input wire [31:0] mc_mask, mc_data,
  input wire mc_prog_req, mc_test_req, mc_done,
  input wire mc_fail_upper, mc_fail_lower, irq
);
  logic [31:0] cq;
  wire [31:0] um, lm;
  wire rq = mc_prog_req | mc_test_req;
  wire rd = pready && !pwrite;
  wire mp = paddr == `OPC_CTRL_ADDR || paddr == `OPC_STAT_ADDR ||
    paddr == `OPC_CMD_ADDR || paddr == `OPC_IRQS_ADDR ||
    paddr == `OPC_IRQM_ADDR;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // control word accepted while idle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cq <= `OPC_ZERO32;
    else if (pready && pwrite && !rq && paddr == `OPC_CTRL_ADDR)
      cq <= pwdata & `OPC_CTRL_WMASK;
  end
  // expected one-hot bit of each enabled bank
  assign um = cq[27] ? `OPC_ONE32 << ((cq[23] ? 24 : 8) + cq[22:20]) : 0;
  assign lm = cq[25] ? `OPC_ONE32 << ((cq[19] ? 16 : 0) + cq[18:16]) : 0;
  a_ready_wait: assert property (psel && !penable |->
    !pready ##1 !pready ##1 pready) else $error("ready timing");
  a_err_map: assert property (pready |-> pslverr == !mp)
    else $error("slave error");
  a_stat_rsvd: assert property (rd && paddr == `OPC_STAT_ADDR |->
    (prdata & 32'hE000_00F5) == 0) else $error("status reserved");
  a_stat_err: assert property (rd && paddr == `OPC_STAT_ADDR |->
    prdata[1] == |prdata[13:12] && prdata[3] == |prdata[15:14])
    else $error("error flags");
  a_ctrl_read: assert property (rd && paddr == `OPC_CTRL_ADDR |->
    prdata == cq) else $error("control readback");
  a_bank_sel: assert property ($rose(mc_prog_req) |->
    mc_mask == (um | lm) && (um | lm) != 0) else $error("mask");
  a_bit_value: assert property ($rose(mc_prog_req) |->
    (mc_data & um) == (um & {32{cq[26]}}) &&
    (mc_data & lm) == (lm & {32{cq[24]}})) else $error("data");
  a_word_addr: assert property ($rose(mc_prog_req) |->
    mc_addr == cq[12:0]) else $error("word address");
  a_req_hold: assert property (rq && !mc_done |=> rq)
    else $error("request dropped");
  a_req_drop: assert property ($rose(mc_done) |-> ##[3:6] !rq)
    else $error("request stuck");
endmodule // opc_ctrl_checker
bind opc_ctrl opc_ctrl_checker chk_u (.pclk, .presetn, .psel, .penable,
  .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .words_left,
  .mc_addr, .fifo_words, .mc_mask, .mc_data, .mc_prog_req, .mc_test_req,
  .mc_done, .mc_fail_upper, .mc_fail_lower, .irq);

// file: tb/opc_mc_model.sv
// behavioural macrocell pair answering the programming slice
`timescale 1ns/10ps
module opc_mc_model (
  // clock and reset
  input wire pclk, presetn,
  // requests and scenario knobs
  input wire mc_prog_req, mc_test_req, fu, fl,
  input wire [7:0] dly,
  // answer pins
  output logic mc_done, mc_fail_upper, mc_fail_lower
);
  logic [7:0] n_q;
  wire rq = mc_prog_req | mc_test_req;
  wire go = rq && !mc_done && n_q == dly;
  // done dly+1 cycles after the request rises, held until the request drops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_q <= 8'h00;
      mc_done <= 0;
      mc_fail_upper <= 0;
      mc_fail_lower <= 0;
    end else begin
      n_q <= rq ? n_q + 8'h01 : 8'h00;
      mc_done <= rq && (mc_done || go);
      // fail pins churn while not qualified by done
      mc_fail_upper <= mc_done ? mc_fail_upper : go ? fu : ~mc_fail_upper;
      mc_fail_lower <= mc_done ? mc_fail_lower : go ? fl : ~mc_fail_lower;
    end
  end
endmodule // opc_mc_model

// file: tb/tb_opc_ctrl.sv
// self-checking bench for the programming slice
`timescale 1ns/10ps
`include "opc_regs.vh"
module tb_opc_ctrl;
  logic pclk, presetn, psel, penable, pwrite, fu, fl, ev;
  logic [31:0] paddr, pwdata, rv;
  logic [12:0] words_left;
  logic [3:0] fifo_words;
  logic [7:0] dly;
  wire [31:0] prdata, mc_mask, mc_data;
  wire [12:0] mc_addr;
  wire pready, pslverr, mc_prog_req, mc_test_req, mc_done;
  wire mc_fail_upper, mc_fail_lower, irq;
  int n_errors, total_checks, k;
  opc_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .words_left, .fifo_words,
    .mc_addr, .mc_mask, .mc_data, .mc_prog_req, .mc_test_req, .mc_done,
    .mc_fail_upper, .mc_fail_lower, .irq);
  opc_mc_model mc_u (.pclk, .presetn, .mc_prog_req, .mc_test_req, .fu,
    .fl, .dly, .mc_done, .mc_fail_upper, .mc_fail_lower);
  // 40 mhz clock
  initial begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end
  task chk(input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer, held until ready
  task apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [31:0] a, d);
    apb(1, a, d);
  endtask
  task rc(input logic [31:0] a, e);
    apb(0, a, `OPC_ZERO32);
    chk(rv, e);
  endtask
  task wait_idle;
    for (k = 0; k < 90 && (mc_prog_req | mc_test_req) !== 1'b0; k++)
      @(posedge pclk);
    repeat (12) @(posedge pclk);
  endtask
  task t_regs;
    rc(`OPC_CTRL_ADDR, `OPC_ZERO32);
    rc(`OPC_IRQM_ADDR, `OPC_ZERO32);
    wr(`OPC_CTRL_ADDR, 32'hFFFF_FFFF);
    rc(`OPC_CTRL_ADDR, `OPC_CTRL_WMASK);
    rc(`OPC_STAT_ADDR, {3'h0, words_left, 4'h0, fifo_words, 8'h00});
    apb(0, 32'h4000_800C, `OPC_ZERO32);
    chk({31'h0000_0000, ev}, `OPC_ONE32);
    $display("t_regs done");
  endtask
  task t_prog(input logic [31:0] c, input logic u, l);
    logic [31:0] um, lm;
    logic eu, el;
    um = c[27] ? `OPC_ONE32 << ((c[23] ? 24 : 8) + c[22:20]) : 0;
    lm = c[25] ? `OPC_ONE32 << ((c[19] ? 16 : 0) + c[18:16]) : 0;
    eu = u & c[27];
    el = l & c[25];
    fu <= u;
    fl <= l;
    wr(`OPC_CTRL_ADDR, c);
    wr(`OPC_CMD_ADDR, `OPC_ONE32);
    if (um | lm) begin
      for (k = 0; k < 20 && mc_prog_req !== 1'b1; k++) @(posedge pclk);
      chk(mc_mask, um | lm);
      chk(mc_data & (um | lm), um & {32{c[26]}} | lm & {32{c[24]}});
      chk({19'h0_0000, mc_addr}, {19'h0_0000, c[12:0]});
      wr(`OPC_CTRL_ADDR, ~c);
      rc(`OPC_CTRL_ADDR, c & `OPC_CTRL_WMASK);
    end
    wait_idle;
    rc(`OPC_STAT_ADDR, {3'h0, words_left, 2'h0, eu, el, fifo_words,
      6'h00, eu | el, 1'b0});
    rc(`OPC_IRQS_ADDR, {30'h0000_0000, eu | el, 1'b1});
    wr(`OPC_IRQS_ADDR, 32'h0000_0003);
    $display("t_prog done");
  endtask
  task t_test;
    fu <= 1;
    fl <= 1;
    dly <= 8'h02;
    words_left <= 13'h0123;
    fifo_words <= 4'h5;
    wr(`OPC_IRQM_ADDR, 32'h0000_0008);
    wr(`OPC_CMD_ADDR, 32'h0000_0002);
    rc(`OPC_CMD_ADDR, 32'h0000_0002);
    repeat (4) @(posedge pclk);
    wait_idle;
    rc(`OPC_STAT_ADDR, {3'h0, words_left, 4'hC, fifo_words, 8'h08});
    chk({31'h0000_0000, irq}, `OPC_ONE32);
    wr(`OPC_IRQM_ADDR, `OPC_ZERO32);
    repeat (2) @(posedge pclk);
    chk({31'h0000_0000, irq}, `OPC_ZERO32);
    wr(`OPC_IRQM_ADDR, 32'h0000_0008);
    wr(`OPC_IRQS_ADDR, 32'h0000_0008);
    repeat (2) @(posedge pclk);
    chk({31'h0000_0000, irq}, `OPC_ZERO32);
    rc(`OPC_IRQS_ADDR, 32'h0000_0004);
    $display("t_test done");
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // reset, then the scenarios
  initial begin
    {presetn, psel, penable, pwrite, fu, fl} = 0;
    paddr = 0;
    pwdata = 0;
    dly = 8'h14;
    words_left = 13'h1A5C;
    fifo_words = 4'hA;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_prog(32'h0ED3_0ABC, 1, 0);
    t_prog(32'h032F_1FFF, 1, 1);
    t_prog(32'h0800_0000, 0, 0);
    t_prog(32'h0000_0F00, 0, 0);
    t_test;
    tally_and_finish;
  end
  // watchdog
  initial begin
    #500000;
    n_errors++;
    tally_and_finish;
  end
endmodule // tb_opc_ctrl
